//--- src/ov_fault_retry_control.sv
// output overvoltage fault response: retry counting, delay timing, warning flag
// assumes fault comparator and control pin are asynchronous; the rest is on core_clk
//
// Behaviour
// R01 - retry codes 100, 101, 110 give four, five, six restart attempts
// R02 - when attempts run out, output stays off until fault cleared
// R03 - attempts spaced by unit count times configured delay unit
// R04 - code 111 retries forever until commanded off, reset, or other fault
// R05 - time field counts delay units for run-on time or retry interval
// R06 - time codes decode to 1, ?, 2, 8, 16, 32, 64, 128 units
// R07 - delay unit length comes from separate time-unit configuration
// R08 - 16-bit overvoltage warning threshold, read and written by word transfers
// R09 - response field: ignore, run-on then retry, shut then retry, off while fault
// R10 - retry code 000 means no restart, 001 to 011 one to three
// R11 - latched fault cleared by status clear, clear-all, reset, off-on, bias loss
// R12 - warning flag set while voltage exceeds threshold, output untouched
// R13 - attempt starts after full delay; count drops at each attempt start
`timescale 1ns/1ps
`default_nettype none

module ov_fault_retry_control (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        cmd_strobe,
  input  wire logic        cmd_write,
  input  wire logic        cmd_word,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata_r,
  output logic             cmd_rvalid_r,
  input  wire logic [15:0] delay_unit_ticks,
  input  wire logic        ov_fault_pin,
  input  wire logic        ctrl_pin_on,
  input  wire logic        operation_on,
  input  wire logic        clear_faults,
  input  wire logic        clear_ov_status,
  input  wire logic [15:0] vout_meas,
  output logic             output_enable_r,
  output logic             ov_fault_status_r,
  output logic             ov_warning_r
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] fault_sync_r;
  logic [1:0] ctrl_sync_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_sync_r <= 2'h0;
      ctrl_sync_r  <= 2'h0;
    end else begin
      fault_sync_r <= {fault_sync_r[0], ov_fault_pin};
      ctrl_sync_r  <= {ctrl_sync_r[0], ctrl_pin_on};
    end
  end

  wire fault = fault_sync_r[1];
  wire run_cmd = ctrl_sync_r[1] & operation_on;

  // ****************************************
  // command-code registers
  // ****************************************
  logic [7:0]  reaction_cfg_r;
  logic [15:0] ov_warning_threshold_r;

  wire wr_reaction = cmd_strobe & cmd_write & ~cmd_word
                     & (cmd_code == ov_retry_pkg::CODE_OV_REACTION);
  wire wr_warning  = cmd_strobe & cmd_write & cmd_word
                     & (cmd_code == ov_retry_pkg::CODE_OV_WARNING);            // [R08]
  wire rd_reaction = ~cmd_word & (cmd_code == ov_retry_pkg::CODE_OV_REACTION);
  wire rd_warning  = cmd_word & (cmd_code == ov_retry_pkg::CODE_OV_WARNING);
  wire [15:0] rd_mux = rd_warning  ? ov_warning_threshold_r :
                       rd_reaction ? {8'h00, reaction_cfg_r} : 16'h0000;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reaction_cfg_r         <= ov_retry_pkg::RST_OV_REACTION;
      ov_warning_threshold_r <= ov_retry_pkg::RST_OV_WARNING;
      cmd_rdata_r            <= 16'h0000;
      cmd_rvalid_r           <= 1'b0;
    end else begin
      if (wr_reaction) reaction_cfg_r <= cmd_wdata[7:0];
      if (wr_warning) ov_warning_threshold_r <= cmd_wdata;                   // [R08]
      cmd_rvalid_r <= cmd_strobe & ~cmd_write;
      if (cmd_strobe & ~cmd_write) cmd_rdata_r <= rd_mux;
    end
  end

  wire [1:0] resp_sel   = reaction_cfg_r[ov_retry_pkg::RESP_MSB:ov_retry_pkg::RESP_LSB];
  wire [2:0] retry_code = reaction_cfg_r[ov_retry_pkg::RETRY_MSB:ov_retry_pkg::RETRY_LSB];
  wire [2:0] time_code  = reaction_cfg_r[ov_retry_pkg::TIME_MSB:ov_retry_pkg::TIME_LSB];

  // ****************************************
  // delay length
  // ****************************************
  logic [7:0] unit_count;
  always_comb begin
    case (time_code)                                                          // [R06] [R05]
      3'h0:    unit_count = 8'h01;
      3'h1:    unit_count = ov_retry_pkg::UNITS_CODE1;
      3'h2:    unit_count = 8'h02;
      3'h3:    unit_count = 8'h08;
      3'h4:    unit_count = 8'h10;
      3'h5:    unit_count = 8'h20;
      3'h6:    unit_count = 8'h40;
      default: unit_count = 8'h80;
    endcase
  end

  // a zero unit would collapse the interval, so it counts as one tick
  wire [15:0] unit_len = (delay_unit_ticks == 16'h0000) ? 16'h0001 : delay_unit_ticks;
  wire [ov_retry_pkg::TIMER_W-1:0] delay_total = {16'h0000, unit_count}
                                                 * {8'h00, unit_len};         // [R03] [R07]

  // ****************************************
  // response state machine
  // ****************************************
  ov_retry_pkg::ov_state_t state_r, state_nxt;
  logic [ov_retry_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic [2:0] retry_left_r, retry_left_nxt;
  logic       run_cmd_d_r;

  wire timer_done = (timer_r == '0);
  wire forever_retry = (retry_code == ov_retry_pkg::RETRY_FOREVER);
  wire can_retry = (retry_code != ov_retry_pkg::RETRY_NONE)
                   & (forever_retry | (retry_left_r != 3'h0));                 // [R10] [R01]
  wire ov_clear = clear_faults | clear_ov_status;
  wire turn_on  = run_cmd & ~run_cmd_d_r;

  always_comb begin
    state_nxt      = state_r;
    timer_nxt      = timer_done ? timer_r : timer_r - {{(ov_retry_pkg::TIMER_W-1){1'b0}}, 1'b1};
    retry_left_nxt = retry_left_r;
    case (state_r)
      ov_retry_pkg::ST_OFF: begin
        if (turn_on) state_nxt = ov_retry_pkg::ST_RUN;                       // [R11]
      end
      ov_retry_pkg::ST_RUN: begin
        retry_left_nxt = retry_code;
        if (fault) begin
          case (resp_sel)                                                     // [R09]
            ov_retry_pkg::RESP_DELAY: begin
              state_nxt = ov_retry_pkg::ST_HOLD;
              timer_nxt = delay_total;
            end
            ov_retry_pkg::RESP_SHUT: begin
              state_nxt = can_retry ? ov_retry_pkg::ST_WAIT : ov_retry_pkg::ST_LATCH;
              timer_nxt = delay_total;
            end
            ov_retry_pkg::RESP_PERSIST: state_nxt = ov_retry_pkg::ST_PERSIST;
            default: state_nxt = ov_retry_pkg::ST_RUN;
          endcase
        end
      end
      ov_retry_pkg::ST_HOLD: begin
        if (timer_done) begin                                                 // [R05]
          if (!fault) state_nxt = ov_retry_pkg::ST_RUN;
          else begin
            state_nxt = can_retry ? ov_retry_pkg::ST_WAIT : ov_retry_pkg::ST_LATCH;
            timer_nxt = delay_total;
          end
        end
      end
      ov_retry_pkg::ST_WAIT: begin
        if (timer_done) begin                                                 // [R13] [R03]
          state_nxt = ov_retry_pkg::ST_TRY;
          timer_nxt = delay_total;
          if (!forever_retry) retry_left_nxt = retry_left_r - 3'h1;           // [R04]
        end
      end
      ov_retry_pkg::ST_TRY: begin
        if (fault) begin
          state_nxt = can_retry ? ov_retry_pkg::ST_WAIT : ov_retry_pkg::ST_LATCH; // [R02]
          timer_nxt = delay_total;
        end else if (timer_done) state_nxt = ov_retry_pkg::ST_RUN;
      end
      ov_retry_pkg::ST_LATCH: begin
        if (ov_clear) state_nxt = ov_retry_pkg::ST_RUN;                       // [R11] [R02]
      end
      ov_retry_pkg::ST_PERSIST: begin
        if (!fault) state_nxt = ov_retry_pkg::ST_RUN;
      end
      default: state_nxt = ov_retry_pkg::ST_OFF;
    endcase
    if (!run_cmd) state_nxt = ov_retry_pkg::ST_OFF;                           // [R04]
  end

  wire on_nxt = (state_nxt == ov_retry_pkg::ST_RUN) | (state_nxt == ov_retry_pkg::ST_HOLD)
                | (state_nxt == ov_retry_pkg::ST_TRY);
  wire fault_event = fault & (resp_sel != ov_retry_pkg::RESP_IGNORE)
                     & (state_r == ov_retry_pkg::ST_RUN);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r           <= ov_retry_pkg::ST_OFF;
      timer_r           <= '0;
      retry_left_r      <= 3'h0;
      run_cmd_d_r       <= 1'b0;
      output_enable_r   <= 1'b0;
      ov_fault_status_r <= 1'b0;
      ov_warning_r      <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      timer_r         <= timer_nxt;
      retry_left_r    <= retry_left_nxt;
      run_cmd_d_r     <= run_cmd;
      output_enable_r <= on_nxt;
      // a new fault in the clearing cycle keeps the flag set
      if (fault_event) ov_fault_status_r <= 1'b1;                            // [R11]
      else if (ov_clear | turn_on) ov_fault_status_r <= 1'b0;
      ov_warning_r <= (vout_meas > ov_warning_threshold_r);                  // [R12]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_latch_off;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_LATCH) |-> !output_enable_r;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("output on while latched"); // [R02]
  property p_try_decrements;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_WAIT && timer_done && run_cmd && !forever_retry)
      |=> retry_left_r == $past(retry_left_r) - 3'h1;
  endproperty
  a_try_decrements: assert property (p_try_decrements) else $error("count not dropped"); // [R13]
  property p_forever_kept;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_WAIT && timer_done && forever_retry)
      |=> retry_left_r == $past(retry_left_r);
  endproperty
  a_forever_kept: assert property (p_forever_kept) else $error("forever count moved"); // [R04]
  property p_no_retry;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_RUN && fault && run_cmd
       && resp_sel == ov_retry_pkg::RESP_SHUT && retry_code == ov_retry_pkg::RETRY_NONE)
      |=> state_r == ov_retry_pkg::ST_LATCH;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retried with code zero"); // [R10]
  property p_attempt_after_delay;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_WAIT && !timer_done) |=> state_r != ov_retry_pkg::ST_TRY;
  endproperty
  a_attempt_after_delay: assert property (p_attempt_after_delay) else $error("early attempt"); // [R03]
  property p_timer_load;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_RUN && fault && run_cmd
       && resp_sel == ov_retry_pkg::RESP_DELAY)
      |=> timer_r == $past(unit_count) * $past(unit_len);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("delay length wrong"); // [R07]
  property p_run_on;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_HOLD && run_cmd && !timer_done) |=> output_enable_r;
  endproperty
  a_run_on: assert property (p_run_on) else $error("output dropped during run-on"); // [R09]
  property p_warn;
    @(posedge core_clk) disable iff (!reset_n)
      (vout_meas > ov_warning_threshold_r) |=> ov_warning_r;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not flagged"); // [R12]
  property p_decode;
    @(posedge core_clk) disable iff (!reset_n)
      (time_code == 3'h3) |-> unit_count == 8'h08;
  endproperty
  a_decode: assert property (p_decode) else $error("time decode wrong"); // [R06]
  property p_word_write;
    @(posedge core_clk) disable iff (!reset_n)
      wr_warning |=> ov_warning_threshold_r == $past(cmd_wdata);
  endproperty
  a_word_write: assert property (p_word_write) else $error("threshold not written"); // [R08]
  property p_clear;
    @(posedge core_clk) disable iff (!reset_n)
      (ov_clear && !fault_event) |=> !ov_fault_status_r;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared"); // [R11]
  property p_cmd_off;
    @(posedge core_clk) disable iff (!reset_n)
      !run_cmd |=> !output_enable_r;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("on while commanded off"); // [R04]
  property p_four_tries;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == ov_retry_pkg::ST_RUN && retry_code == 3'h4) |=> retry_left_r == 3'h4;
  endproperty
  a_four_tries: assert property (p_four_tries) else $error("attempt count wrong"); // [R01]

endmodule

`default_nettype wire

//--- src/ov_retry_pkg.sv
// constants for the output overvoltage fault-response block
// assumes one 20 MHz controller clock and command-code register access
package ov_retry_pkg;

  // ****************************************
  // command codes and reset values
  // ****************************************
  localparam logic [7:0]  CODE_OV_REACTION   = 8'h41;
  localparam logic [7:0]  CODE_OV_WARNING    = 8'h42;
  localparam logic [7:0]  CODE_TIME_UNIT_REF = 8'hD2;
  localparam logic [7:0]  RST_OV_REACTION    = 8'h80;
  localparam logic [15:0] RST_OV_WARNING     = 16'hFFFF;

  // ****************************************
  // reaction field layout
  // ****************************************
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int TIME_MSB  = 2;
  localparam int TIME_LSB  = 0;

  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_DELAY   = 2'h1;
  localparam logic [1:0] RESP_SHUT    = 2'h2;
  localparam logic [1:0] RESP_PERSIST = 2'h3;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // undocumented time code 1 given four units, a count between those of codes 2 and 3
  localparam logic [7:0] UNITS_CODE1 = 8'h04;

  localparam int TIMER_W = 24;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_RUN     = 3'b001,
    ST_HOLD    = 3'b010,
    ST_WAIT    = 3'b011,
    ST_TRY     = 3'b100,
    ST_LATCH   = 3'b101,
    ST_PERSIST = 3'b110
  } ov_state_t;

endpackage

//--- tb/ov_host_model.sv
// host model: command-code accesses and clear pulses toward the converter
// assumes one core_clk domain; lines change 5 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module ov_host_model (
  input  wire logic        core_clk,
  output logic             cmd_strobe,
  output logic             cmd_write,
  output logic             cmd_word,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_wdata,
  output logic             clear_faults,
  output logic             clear_ov_status,
  input  wire logic [15:0] cmd_rdata_r,
  input  wire logic        cmd_rvalid_r
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    {cmd_strobe, cmd_write, cmd_word, cmd_code, cmd_wdata} = '0;
    {clear_faults, clear_ov_status} = 2'h0;
  end

  // released code and data lines show the inverse so stale data never looks valid
  task automatic go(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    #5;
    cmd_strobe = 1'b1;
    cmd_write  = w;
    cmd_word   = wd;
    cmd_code   = c;
    cmd_wdata  = d;
    @(posedge core_clk);
    #5;
    cmd_strobe = 1'b0;
    cmd_code   = ~c;
    cmd_wdata  = ~d;
  endtask

  task automatic wr(input logic [7:0] c, input logic wd, input logic [15:0] d);
    go(1'b1, wd, c, d);
  endtask

  task automatic rd(input logic [7:0] c, input logic wd, output logic [15:0] d, output logic v);
    go(1'b0, wd, c, 16'h0000);
    v = cmd_rvalid_r;
    d = cmd_rdata_r;
  endtask

  // one-cycle pulse: 0 clears all faults, 1 only the overvoltage bit
  task automatic clr(input logic which);
    @(posedge core_clk);
    #5;
    clear_faults    = ~which;
    clear_ov_status = which;
    @(posedge core_clk);
    #5;
    {clear_faults, clear_ov_status} = 2'h0;
  endtask
endmodule
`default_nettype wire

//--- tb/ov_fault_retry_control_tb.sv
// testbench for the overvoltage fault-response block
// assumes ov_host_model drives the command port; delay unit kept small
`timescale 1ns/1ps
`default_nettype none

module ov_fault_retry_control_tb;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int UNITS [8] = '{1, 4, 2, 8, 16, 32, 64, 128};
  logic        core_clk;
  logic        reset_n;
  logic [15:0] delay_unit_ticks;
  logic        ov_fault_pin;
  logic        ctrl_pin_on;
  logic        operation_on;
  logic [15:0] vout_meas;
  wire         cmd_strobe, cmd_write, cmd_word, clear_faults, clear_ov_status;
  wire  [7:0]  cmd_code;
  wire  [15:0] cmd_wdata, cmd_rdata_r;
  wire         cmd_rvalid_r, output_enable_r, ov_fault_status_r, ov_warning_r;
  int          n_fail, comparisons, n_rise, off_cnt, last_off;
  logic        en_q;

  ov_host_model host (.core_clk(core_clk), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write),
    .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .clear_ov_status(clear_ov_status),
    .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r));

  ov_fault_retry_control dut (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_strobe(cmd_strobe), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_r(cmd_rdata_r),
    .cmd_rvalid_r(cmd_rvalid_r), .delay_unit_ticks(delay_unit_ticks),
    .ov_fault_pin(ov_fault_pin), .ctrl_pin_on(ctrl_pin_on), .operation_on(operation_on),
    .clear_faults(clear_faults), .clear_ov_status(clear_ov_status),
    .vout_meas(vout_meas), .output_enable_r(output_enable_r),
    .ov_fault_status_r(ov_fault_status_r), .ov_warning_r(ov_warning_r));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // negedge sampling keeps the monitor clear of the launching edge
  always @(negedge core_clk) begin
    if (output_enable_r === 1'b1 && en_q !== 1'b1) begin
      n_rise++;
      last_off = off_cnt;
    end
    off_cnt = (output_enable_r === 1'b1) ? 0 : off_cnt + 1;
    en_q = output_enable_r;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic restart(input logic [15:0] ticks, input logic [7:0] cfg);
    step(1);
    reset_n = 1'b0;
    operation_on = 1'b0;
    ov_fault_pin = 1'b0;
    delay_unit_ticks = ticks;
    step(6);
    reset_n = 1'b1;
    operation_on = 1'b1;
    host.wr(8'h41, 1'b0, {8'h00, cfg});
    step(6);
    chk(output_enable_r, 1'b1, "turn on");
    n_rise = 0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [15:0] d;
    logic        v;
    host.rd(8'h41, 1'b0, d, v);
    chk(d, {8'h00, ov_retry_pkg::RST_OV_REACTION}, "cfg reset");
    chk(v, 1'b1, "rvalid");
    host.rd(8'h42, 1'b1, d, v);
    chk(d, ov_retry_pkg::RST_OV_WARNING, "limit reset");
    step(1);
    chk(cmd_rvalid_r, 1'b0, "rvalid one cycle");
    host.wr(8'h42, 1'b1, 16'h1234);
    host.wr(8'h42, 1'b0, 16'h5555);
    host.rd(8'h42, 1'b1, d, v);
    chk(d, 16'h1234, "limit readback");
    host.rd(8'h43, 1'b1, d, v);
    chk(d, 16'h0000, "unmapped read");
  endtask

  task automatic t_warn();
    vout_meas = 16'h1235;
    step(3);
    chk(ov_warning_r, 1'b1, "warning set");
    chk(output_enable_r, 1'b1, "output kept");
    vout_meas = 16'h1234;
    step(3);
    chk(ov_warning_r, 1'b0, "warning at limit");
  endtask

  task automatic t_retry();
    for (int c = 0; c < 7; c++) begin
      restart(16'h0001, {2'b10, c[2:0], 3'b000});
      ov_fault_pin = 1'b1;
      step(80);
      chk(16'(n_rise), 16'(c), "attempts");
      chk(output_enable_r, 1'b0, "latched off");
      chk(ov_fault_status_r, 1'b1, "status set");
      ov_fault_pin = 1'b0;
      step(8);
      chk(output_enable_r, 1'b0, "stays off");
      host.clr(c[0]);
      step(3);
      chk(output_enable_r, 1'b1, "cleared on");
      chk(ov_fault_status_r, 1'b0, "status cleared");
    end
  endtask

  task automatic t_time();
    for (int t = 0; t < 8; t++) begin
      restart(16'h0002, {5'b10001, t[2:0]});
      ov_fault_pin = 1'b1;
      step(UNITS[t] * 2 + 12);
      chk(16'(last_off), 16'(UNITS[t] * 2 + 1), "spacing");
    end
  endtask

  task automatic t_forever();
    restart(16'h0001, 8'hB8);
    ov_fault_pin = 1'b1;
    step(100);
    chk(n_rise > 10, 1'b1, "unlimited");
    ctrl_pin_on = 1'b0;
    step(5);
    n_rise = 0;
    step(30);
    chk(16'(n_rise), 16'h0000, "commanded off");
    ov_fault_pin = 1'b0;
    ctrl_pin_on = 1'b1;
    step(6);
    chk(output_enable_r, 1'b1, "off-on");
    chk(ov_fault_status_r, 1'b0, "off-on status");
  endtask

  task automatic t_modes();
    restart(16'h0001, 8'h00);
    ov_fault_pin = 1'b1;
    step(20);
    chk(output_enable_r, 1'b1, "ignore");
    chk(ov_fault_status_r, 1'b0, "ignore status");
    restart(16'h0001, 8'hC0);
    ov_fault_pin = 1'b1;
    step(6);
    chk(output_enable_r, 1'b0, "persist off");
    ov_fault_pin = 1'b0;
    step(6);
    chk(output_enable_r, 1'b1, "persist resumes");
    restart(16'h0002, 8'h43);
    ov_fault_pin = 1'b1;
    step(12);
    chk(output_enable_r, 1'b1, "run-on");
    step(12);
    chk(output_enable_r, 1'b0, "run-on expiry");
    restart(16'h0002, 8'h43);
    ov_fault_pin = 1'b1;
    step(6);
    ov_fault_pin = 1'b0;
    step(30);
    chk(output_enable_r, 1'b1, "run-on recovers");
    restart(16'h0001, 8'h8B);
    ov_fault_pin = 1'b1;
    step(4);
    ov_fault_pin = 1'b0;
    step(30);
    chk(output_enable_r, 1'b1, "attempt survives");
    chk(16'(n_rise), 16'h0001, "one attempt");
  endtask

  initial begin
    {n_fail, comparisons, n_rise, off_cnt, last_off} = '0;
    {reset_n, ov_fault_pin, operation_on, en_q} = 4'h0;
    ctrl_pin_on = 1'b1;
    delay_unit_ticks = 16'h0001;
    vout_meas = 16'h0000;
    step(6);
    reset_n = 1'b1;
    operation_on = 1'b1;
    t_regs();
    t_warn();
    t_retry();
    t_time();
    t_forever();
    t_modes();
    complete_run();
  end

  initial begin
    #(50 * 10000);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
